// [logic/tmc_config_regs.sv]
`timescale 1ns/1ps
module tmc_config_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmc_pkg::TMC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Terminal engine state
    input wire tmc_pkg::tmc_mode_t mode,
    input wire logic rt_msg_busy,
    input wire logic msg_mon_storing,
    input wire logic cmd_illegal,
    input wire logic [10:0] gen_status,
    input wire tmc_pkg::tmc_rx_t rx,
    // Status word out
    output logic [10:0] tx_status,
    // Monitor store control
    output logic store_word,
    output logic [15:0] store_data,
    output logic mon_online,
    // External trigger pin
    input wire logic external_trigger_input,
    // Interrupt condition events
    input wire logic [tmc_pkg::TMC_INT1_W-1:0] int1_ev,
    input wire logic [tmc_pkg::TMC_INT2_W-1:0] int2_ev,
    output logic int_req,
    // Shared memory parity
    input wire tmc_pkg::tmc_mem_t mem,
    output logic mem_wr_par,
    // Configuration two fields to the engine
    output logic [15:0] config_two_out
);
    import tmc_pkg::*;

    logic [15:0] config_one_ff;
    logic [15:0] config_two_ff;
    logic [15:0] config_three_ff;
    logic [15:0] trig_pat_ff;
    logic [TMC_INT1_W-1:0] mask1_ff;
    logic [TMC_INT2_W-1:0] mask2_ff;
    logic [TMC_INT1_W-1:0] stat1_ff;
    logic [TMC_INT2_W-1:0] stat2_ff;
    logic triggered_ff;
    logic store_ff;
    logic [15:0] store_data_ff;
    logic [31:0] prdata_ff;
    tmc_mt_state_t mt_state_ff;
    tmc_mt_state_t nxt_mt_state;

    logic setup;
    logic wr_en;
    logic [5:0] idx;
    logic mapped;
    logic [15:0] wmask;
    logic enh;
    logic alt_en;
    logic mt_enh;
    logic word_mt;
    logic trig_on;
    logic ext_pulse;
    logic ext_evt;
    logic match_cs;
    logic match_cmd;
    logic start_cmd;
    logic soft_reset;
    logic start_hit;
    logic stop_hit;
    logic enh_int;
    logic par_en;
    logic par_err;
    logic [TMC_INT1_W-1:0] eff_mask1;
    logic [TMC_INT2_W-1:0] eff_mask2;
    logic [TMC_INT1_W-1:0] ev1_all;
    logic [TMC_INT1_W-1:0] set1;
    logic [TMC_INT2_W-1:0] set2;
    logic [15:0] cfg1_rd;
    // Byte-lane merge results for the narrower mask registers
    logic [15:0] mask1_wr;
    logic [15:0] mask2_wr;

    // Bus decode
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && mapped;
    assign idx = paddr[TMC_AW-1:2];
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_ff;

    always_comb begin
        unique case (idx)
            TMC_IDX_CFG1, TMC_IDX_CFG2, TMC_IDX_CFG3, TMC_IDX_START, TMC_IDX_TRIG,
            TMC_IDX_MASK1, TMC_IDX_MASK2, TMC_IDX_STAT1, TMC_IDX_STAT2: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [15:0] m);
        merge = (old & ~m) | (wd[15:0] & m);
    endfunction

    // Mode qualifiers
    assign enh = config_three_ff[TMC_C3_ENH];
    assign alt_en = enh && config_three_ff[TMC_C3_ALT_STS] && (mode == TMC_RT);
    assign mt_enh = enh && ((mode == TMC_WMT) || (mode == TMC_MMT));
    assign word_mt = mt_enh && (mode == TMC_WMT);
    assign trig_on = word_mt && config_one_ff[TMC_C1_TRIG_EN];
    assign enh_int = enh && config_two_ff[TMC_C2_ENH_INT];
    assign par_en = enh && config_two_ff[TMC_C2_PAR_EN];

    // Software monitor commands
    assign start_cmd = wr_en && (idx == TMC_IDX_START) && pstrb[0] && pwdata[TMC_SR_MT_START];
    assign soft_reset = wr_en && (idx == TMC_IDX_START) && pstrb[0] && pwdata[TMC_SR_RESET];

    tmc_trig_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(external_trigger_input),
        .pulse(ext_pulse)
    );

    // Trigger events
    assign ext_evt = trig_on && config_one_ff[TMC_C1_EXT_EN] && ext_pulse;
    assign match_cs = rx.valid && rx.clean && (rx.is_cmd || rx.is_status) && (rx.data == trig_pat_ff);
    assign match_cmd = match_cs && rx.is_cmd;
    assign start_hit = trig_on && config_one_ff[TMC_C1_START_ON] && (match_cs || ext_evt);
    assign stop_hit = trig_on && config_one_ff[TMC_C1_STOP_ON] && ((trig_on && match_cmd) || ext_evt);

    // Monitor state
    always_comb begin
        nxt_mt_state = mt_state_ff;
        unique case (mt_state_ff)
            TMC_MT_OFF: begin
                nxt_mt_state = TMC_MT_OFF;
            end
            TMC_MT_WAIT: begin
                if (start_hit) begin
                    nxt_mt_state = TMC_MT_STORE;
                end
            end
            TMC_MT_STORE: begin
                if (stop_hit) begin
                    nxt_mt_state = TMC_MT_OFF;
                end
            end
            default: nxt_mt_state = TMC_MT_OFF;
        endcase
        if (start_cmd && mt_enh) begin
            nxt_mt_state = (trig_on && config_one_ff[TMC_C1_START_ON]) ? TMC_MT_WAIT : TMC_MT_STORE;
        end
        if (soft_reset || !mt_enh) begin
            nxt_mt_state = TMC_MT_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mt_state_ff <= TMC_MT_OFF;
        end else begin
            mt_state_ff <= nxt_mt_state;
        end
    end

    assign mon_online = (mt_state_ff != TMC_MT_OFF);

    // Triggered flag; a trigger stop leaves it set until a start command, a soft reset or leaving word monitor mode
    // A trigger in the same cycle as a clear wins, so no event is lost
    always_ff @(posedge clk) begin
        if (!nrst) begin
            triggered_ff <= 1'b0;
        end else if (mon_online && (match_cmd || ext_evt) && trig_on) begin
            triggered_ff <= 1'b1;
        end else if (start_cmd || soft_reset || !word_mt) begin
            triggered_ff <= 1'b0;
        end
    end

    // Word storing strobe, matching word included at both ends
    always_ff @(posedge clk) begin
        if (!nrst) begin
            store_ff <= 1'b0;
            store_data_ff <= TMC_RST_VAL;
        end else begin
            store_ff <= rx.valid && word_mt &&
                ((mt_state_ff == TMC_MT_STORE) || ((mt_state_ff == TMC_MT_WAIT) && start_hit));
            if (rx.valid) begin
                store_data_ff <= rx.data;
            end
        end
    end

    assign store_word = store_ff;
    assign store_data = store_data_ff;

    // Transmitted status word; index 10 is bit time 9, index 0 is bit time 19
    always_comb begin
        if (alt_en) begin
            tx_status = config_one_ff[TMC_C1_OVR_HI:TMC_C1_OVR_LO];
            tx_status[10] = config_one_ff[TMC_C1_OVR_HI] | cmd_illegal;
        end else begin
            tx_status = gen_status;
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            config_one_ff <= TMC_RST_VAL;
            config_two_ff <= TMC_RST_VAL;
            config_three_ff <= TMC_RST_VAL;
            trig_pat_ff <= TMC_RST_VAL;
        end else if (wr_en) begin
            unique case (idx)
                TMC_IDX_CFG1: config_one_ff <= merge(config_one_ff, pwdata, wmask);
                TMC_IDX_CFG2: config_two_ff <= merge(config_two_ff, pwdata, wmask);
                TMC_IDX_CFG3: config_three_ff <= merge(config_three_ff, pwdata, wmask);
                TMC_IDX_TRIG: trig_pat_ff <= merge(trig_pat_ff, pwdata, wmask);
                default: ;
            endcase
        end
    end

    assign config_two_out = config_two_ff;

    assign mask1_wr = merge({1'b0, mask1_ff}, pwdata, wmask);
    assign mask2_wr = merge({2'b00, mask2_ff}, pwdata, wmask);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mask1_ff <= '0;
            mask2_ff <= '0;
        end else if (wr_en && (idx == TMC_IDX_MASK1)) begin
            mask1_ff <= mask1_wr[TMC_INT1_W-1:0];
        end else if (wr_en && (idx == TMC_IDX_MASK2)) begin
            mask2_ff <= mask2_wr[TMC_INT2_W-1:0];
        end
    end

    // Memory parity
    tmc_parity u_par (
        .clk(clk),
        .nrst(nrst),
        .en(par_en),
        .mem(mem),
        .wr_par(mem_wr_par),
        .err(par_err)
    );

    // Interrupt enabling and status setting
    assign eff_mask1 = enh_int ? mask1_ff : {{(TMC_INT1_W-TMC_INT1_BASIC_W){1'b0}},
        mask1_ff[TMC_INT1_BASIC_W-1:0]};
    assign eff_mask2 = enh_int ? mask2_ff : '0;
    always_comb begin
        ev1_all = int1_ev;
        ev1_all[TMC_INT1_PAR_BIT] = int1_ev[TMC_INT1_PAR_BIT] | par_err;
    end
    assign set1 = enh_int ? ev1_all : (ev1_all & eff_mask1);
    assign set2 = enh_int ? int2_ev : (int2_ev & eff_mask2);

    // Write one clears a status bit; a new event in the same cycle wins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stat1_ff <= '0;
            stat2_ff <= '0;
        end else begin
            if (wr_en && (idx == TMC_IDX_STAT1)) begin
                stat1_ff <= (stat1_ff & ~(pwdata[TMC_INT1_W-1:0] & wmask[TMC_INT1_W-1:0])) | set1;
            end else begin
                stat1_ff <= stat1_ff | set1;
            end
            if (wr_en && (idx == TMC_IDX_STAT2)) begin
                stat2_ff <= (stat2_ff & ~(pwdata[TMC_INT2_W-1:0] & wmask[TMC_INT2_W-1:0])) | set2;
            end else begin
                stat2_ff <= stat2_ff | set2;
            end
        end
    end

    assign int_req = |(stat1_ff & eff_mask1) || |(stat2_ff & eff_mask2);

    // Configuration one readback with mode-dependent status bits
    always_comb begin
        cfg1_rd = config_one_ff;
        cfg1_rd[TMC_C1_ACTIVE] = 1'b0;
        if (mode == TMC_RT) begin
            cfg1_rd[TMC_C1_ACTIVE] = enh && rt_msg_busy;
        end else if (mt_enh) begin
            cfg1_rd[TMC_C1_ONLINE] = mon_online;
            cfg1_rd[TMC_C1_TRIGGERED] = word_mt && triggered_ff;
            cfg1_rd[TMC_C1_ACTIVE] = word_mt ? mon_online : (mon_online && msg_mon_storing);
        end
    end

    // Read data captured in the setup phase, no wait states
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata_ff <= '0;
        end else if (setup && !pwrite) begin
            prdata_ff <= '0;
            unique case (idx)
                TMC_IDX_CFG1: prdata_ff[15:0] <= cfg1_rd;
                TMC_IDX_CFG2: prdata_ff[15:0] <= config_two_ff;
                TMC_IDX_CFG3: prdata_ff[15:0] <= config_three_ff;
                TMC_IDX_TRIG: prdata_ff[15:0] <= trig_pat_ff;
                TMC_IDX_MASK1: prdata_ff[TMC_INT1_W-1:0] <= mask1_ff;
                TMC_IDX_MASK2: prdata_ff[TMC_INT2_W-1:0] <= mask2_ff;
                TMC_IDX_STAT1: prdata_ff[TMC_INT1_W-1:0] <= stat1_ff;
                TMC_IDX_STAT2: prdata_ff[TMC_INT2_W-1:0] <= stat2_ff;
                default: ;
            endcase
        end
    end
endmodule // tmc_config_regs

// [logic/tmc_pkg.sv]
package tmc_pkg;
    localparam int TMC_DW = 16;
    localparam int TMC_AW = 8;
    // Register indices; byte address is four times the index
    localparam logic [5:0] TMC_IDX_CFG1 = 6'h00;
    localparam logic [5:0] TMC_IDX_CFG2 = 6'h02;
    localparam logic [5:0] TMC_IDX_CFG3 = 6'h03;
    localparam logic [5:0] TMC_IDX_START = 6'h04;
    localparam logic [5:0] TMC_IDX_TRIG = 6'h05;
    localparam logic [5:0] TMC_IDX_MASK1 = 6'h06;
    localparam logic [5:0] TMC_IDX_MASK2 = 6'h07;
    localparam logic [5:0] TMC_IDX_STAT1 = 6'h08;
    localparam logic [5:0] TMC_IDX_STAT2 = 6'h09;
    localparam logic [15:0] TMC_RST_VAL = 16'h0000;
    // Configuration one fields
    localparam int TMC_C1_TRIG_EN = 11;
    localparam int TMC_C1_START_ON = 10;
    localparam int TMC_C1_STOP_ON = 9;
    localparam int TMC_C1_EXT_EN = 7;
    localparam int TMC_C1_ONLINE = 2;
    localparam int TMC_C1_TRIGGERED = 1;
    localparam int TMC_C1_ACTIVE = 0;
    localparam int TMC_C1_OVR_HI = 11;
    localparam int TMC_C1_OVR_LO = 1;
    // Configuration two fields
    localparam int TMC_C2_ENH_INT = 15;
    localparam int TMC_C2_PAR_EN = 14;
    // Configuration three fields
    localparam int TMC_C3_ENH = 15;
    localparam int TMC_C3_ALT_STS = 5;
    // Start/reset command bits
    localparam int TMC_SR_RESET = 0;
    localparam int TMC_SR_MT_START = 1;
    // Interrupt layout
    localparam int TMC_INT1_W = 15;
    localparam int TMC_INT2_W = 14;
    localparam int TMC_INT1_BASIC_W = 8;
    localparam int TMC_INT1_PAR_BIT = 14;
    localparam logic TMC_PAR_ODD = 1'b1;

    typedef enum logic [1:0] {
        TMC_BC = 2'b00,
        TMC_RT = 2'b01,
        TMC_WMT = 2'b10,
        TMC_MMT = 2'b11
    } tmc_mode_t;

    typedef enum logic [1:0] {
        TMC_MT_OFF = 2'b00,
        TMC_MT_WAIT = 2'b01,
        TMC_MT_STORE = 2'b10
    } tmc_mt_state_t;

    typedef struct packed {
        logic valid;
        logic is_cmd;
        logic is_status;
        logic clean;
        logic [15:0] data;
    } tmc_rx_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] data;
        logic par;
    } tmc_mem_t;
endpackage

// [logic/tmc_trig_sync.sv]
`timescale 1ns/1ps
module tmc_trig_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Asynchronous pin and its event
    input wire logic pin,
    output logic pulse
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;
    logic pulse_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Level is accepted only when the last two stages agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            lvl_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            if (s2_ff == s3_ff) begin
                lvl_ff <= s3_ff;
            end
            pulse_ff <= (s2_ff == s3_ff) && s3_ff && !lvl_ff;
        end
    end

    assign pulse = pulse_ff;
endmodule // tmc_trig_sync

// [logic/tmc_parity.sv]
`timescale 1ns/1ps
module tmc_parity (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic en,
    // Memory access
    input wire tmc_pkg::tmc_mem_t mem,
    output logic wr_par,
    output logic err
);
    import tmc_pkg::*;

    logic err_ff;

    // Seventeenth bit for every write while parity is enabled, held at zero otherwise
    assign wr_par = en & (^mem.data ^ TMC_PAR_ODD);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            err_ff <= 1'b0;
        end else begin
            err_ff <= en && mem.rd && (mem.par != (^mem.data ^ TMC_PAR_ODD));
        end
    end

    assign err = err_ff;
endmodule // tmc_parity

// [bench/tmc_cfg_asserts.sv]
`timescale 1ns/1ps
module tmc_cfg_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tmc_pkg::TMC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Engine side
    input wire tmc_pkg::tmc_mode_t mode,
    input wire logic [10:0] gen_status,
    input wire tmc_pkg::tmc_rx_t rx,
    input wire logic [10:0] tx_status,
    input wire logic store_word,
    input wire logic [15:0] store_data,
    input wire logic mon_online,
    input wire logic mem_wr_par,
    input wire logic [15:0] config_two_out
);
    import tmc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_cfg2_wr;
        psel && penable && pwrite && paddr[7:2] == TMC_IDX_CFG2 && pstrb[1:0] == 2'b11;
    endsequence
    property p_cfg2_wr;
        s_cfg2_wr |=> config_two_out == $past(pwdata[15:0]);
    endproperty
    property p_ready;
        psel && penable |-> pready;
    endproperty
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    property p_rd_hi;
        prdata[31:16] == 16'h0000;
    endproperty
    property p_tx_gen;
        mode != TMC_RT |-> tx_status == gen_status;
    endproperty
    property p_store_src;
        store_word |-> $past(rx.valid) && store_data == $past(rx.data);
    endproperty
    property p_store_online;
        store_word |-> $past(mon_online);
    endproperty
    property p_par_off;
        !config_two_out[TMC_C2_PAR_EN] |-> !mem_wr_par;
    endproperty

    a_cfg2_wr: assert property (p_cfg2_wr) else $error("config two copy not updated");
    a_ready: assert property (p_ready) else $error("pready low in access");
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    a_rd_hi: assert property (p_rd_hi) else $error("read data upper half set");
    a_tx_gen: assert property (p_tx_gen) else $error("status word overridden");
    a_store_src: assert property (p_store_src) else $error("stored word mismatch");
    a_store_online: assert property (p_store_online) else $error("store while off-line");
    a_par_off: assert property (p_par_off) else $error("parity bit while disabled");
endmodule // tmc_cfg_asserts

bind tmc_config_regs tmc_cfg_asserts u_chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .mode, .gen_status, .rx, .tx_status, .store_word, .store_data, .mon_online,
    .mem_wr_par, .config_two_out);

// [bench/tmc_bus_model.sv]
`timescale 1ns/1ps
module tmc_bus_model (
    // Clock
    input wire logic clk,
    // Received words and trigger pin
    output tmc_pkg::tmc_rx_t rx,
    output logic ext
);
    import tmc_pkg::*;
    initial begin
        rx = '0;
        ext = 1'b0;
    end
    task automatic send(input logic [15:0] d, input logic c);
        @(posedge clk);
        rx <= '{1'b1, c, !c, 1'b1, d};
        @(posedge clk);
        rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~d};
    endtask
    // Held four clocks so the synchroniser cannot miss it
    task automatic ext_pulse();
        @(posedge clk);
        ext <= 1'b1;
        repeat (4) @(posedge clk);
        ext <= 1'b0;
    endtask
endmodule // tmc_bus_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    import tmc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [TMC_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    tmc_mode_t mode = TMC_BC;
    logic rt_msg_busy = 1'b0, msg_mon_storing = 1'b0, cmd_illegal = 1'b0;
    logic [10:0] gen_status = 11'h5a5, tx_status;
    tmc_rx_t rx;
    logic store_word, mon_online, ext, int_req, mem_wr_par;
    logic [15:0] store_data, config_two_out;
    logic [TMC_INT1_W-1:0] int1_ev = '0;
    logic [TMC_INT2_W-1:0] int2_ev = '0;
    tmc_mem_t mem = '0;
    int miscompares = 0, comparisons = 0;
    always #50 clk = ~clk;

    tmc_bus_model u_bus (.clk, .rx, .ext);
    tmc_config_regs dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
        .pslverr, .mode, .rt_msg_busy, .msg_mon_storing, .cmd_illegal, .gen_status, .rx, .tx_status, .store_word,
        .store_data, .mon_online, .external_trigger_input(ext), .int1_ev, .int2_ev, .int_req, .mem, .mem_wr_par,
        .config_two_out);

    task automatic end_sim();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [5:0] idx, input logic w, input logic [15:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] idx, input logic [15:0] exp);
        apb(idx, 1'b0, 16'h0000);
        chk(q, {16'h0000, exp});
    endtask
    task automatic ev(input logic [14:0] a, input logic [13:0] b);
        @(posedge clk);
        int1_ev <= a;
        int2_ev <= b;
        @(posedge clk);
        int1_ev <= '0;
        int2_ev <= '0;
    endtask
    task automatic sw(input logic [15:0] d, input logic c, input logic s);
        u_bus.send(d, c);
        #1;
        chk(32'(store_word), 32'(s));
        if (s) chk(32'(store_data), 32'(d));
    endtask
    task automatic mwr(input logic [15:0] d, input logic p);
        @(posedge clk);
        mem <= '{1'b1, 1'b0, d, 1'b0};
        #1;
        chk(32'(mem_wr_par), 32'(p));
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdc(TMC_IDX_CFG2, 16'h0000);
        apb(TMC_IDX_CFG2, 1'b1, 16'hffff);
        rdc(TMC_IDX_CFG2, 16'hffff);
        apb(TMC_IDX_CFG2, 1'b1, 16'ha5c3);
        rdc(TMC_IDX_CFG2, 16'ha5c3);
        chk(32'(config_two_out), 32'h0000_a5c3);
        apb(6'h0f, 1'b0, 16'h0000);
        chk(32'(e), 32'h0000_0001);
        $display("registers done");
        mode <= TMC_RT;
        apb(TMC_IDX_CFG3, 1'b1, 16'h8020);
        apb(TMC_IDX_CFG1, 1'b1, 16'h0554);
        #1;
        chk(32'(tx_status), 32'h0000_02aa);
        @(posedge clk);
        cmd_illegal <= 1'b1;
        rt_msg_busy <= 1'b1;
        #1;
        chk(32'(tx_status), 32'h0000_06aa);
        rdc(TMC_IDX_CFG1, 16'h0555);
        apb(TMC_IDX_CFG3, 1'b1, 16'h0020);
        #1;
        chk(32'(tx_status), 32'(gen_status));
        rdc(TMC_IDX_CFG1, 16'h0554);
        $display("status word done");
        mode <= TMC_WMT;
        cmd_illegal <= 1'b0;
        rt_msg_busy <= 1'b0;
        apb(TMC_IDX_CFG3, 1'b1, 16'h8000);
        apb(TMC_IDX_TRIG, 1'b1, 16'h1234);
        apb(TMC_IDX_CFG1, 1'b1, 16'h0e00);
        apb(TMC_IDX_START, 1'b1, 16'h0002);
        rdc(TMC_IDX_CFG1, 16'h0e05);
        sw(16'h1235, 1'b1, 1'b0);
        sw(16'h1234, 1'b1, 1'b1);
        rdc(TMC_IDX_CFG1, 16'h0e07);
        sw(16'h0042, 1'b0, 1'b1);
        sw(16'h1234, 1'b1, 1'b1);
        sw(16'h0042, 1'b0, 1'b0);
        rdc(TMC_IDX_CFG1, 16'h0e02);
        apb(TMC_IDX_START, 1'b1, 16'h0002);
        rdc(TMC_IDX_CFG1, 16'h0e05);
        apb(TMC_IDX_CFG1, 1'b1, 16'h0c00);
        u_bus.ext_pulse();
        repeat (10) @(posedge clk);
        rdc(TMC_IDX_CFG1, 16'h0c05);
        apb(TMC_IDX_CFG1, 1'b1, 16'h0c80);
        u_bus.ext_pulse();
        repeat (10) @(posedge clk);
        rdc(TMC_IDX_CFG1, 16'h0c87);
        $display("word monitor done");
        mode <= TMC_MMT;
        apb(TMC_IDX_START, 1'b1, 16'h0002);
        u_bus.send(16'h1234, 1'b1);
        rdc(TMC_IDX_CFG1, 16'h0c84);
        msg_mon_storing <= 1'b1;
        rdc(TMC_IDX_CFG1, 16'h0c85);
        apb(TMC_IDX_START, 1'b1, 16'h0001);
        rdc(TMC_IDX_CFG1, 16'h0c80);
        mode <= TMC_WMT;
        msg_mon_storing <= 1'b0;
        apb(TMC_IDX_CFG3, 1'b1, 16'h0000);
        apb(TMC_IDX_START, 1'b1, 16'h0002);
        rdc(TMC_IDX_CFG1, 16'h0c80);
        chk(32'(mon_online), 32'h0000_0000);
        $display("message monitor done");
        apb(TMC_IDX_CFG3, 1'b1, 16'h8000);
        apb(TMC_IDX_CFG2, 1'b1, 16'h0000);
        apb(TMC_IDX_MASK1, 1'b1, 16'h0101);
        ev(15'h0101, 14'h0001);
        rdc(TMC_IDX_STAT1, 16'h0001);
        rdc(TMC_IDX_STAT2, 16'h0000);
        chk(32'(int_req), 32'h0000_0001);
        apb(TMC_IDX_STAT1, 1'b1, 16'hffff);
        #1;
        chk(32'(int_req), 32'h0000_0000);
        apb(TMC_IDX_CFG2, 1'b1, 16'h8000);
        apb(TMC_IDX_MASK1, 1'b1, 16'h0000);
        ev(15'h0100, 14'h0001);
        rdc(TMC_IDX_STAT1, 16'h0100);
        rdc(TMC_IDX_STAT2, 16'h0001);
        chk(32'(int_req), 32'h0000_0000);
        apb(TMC_IDX_MASK2, 1'b1, 16'h0001);
        #1;
        chk(32'(int_req), 32'h0000_0001);
        apb(TMC_IDX_STAT1, 1'b1, 16'hffff);
        apb(TMC_IDX_STAT2, 1'b1, 16'hffff);
        $display("interrupts done");
        apb(TMC_IDX_CFG2, 1'b1, 16'hc000);
        apb(TMC_IDX_MASK1, 1'b1, 16'h4000);
        mwr(16'h0001, 1'b0);
        mwr(16'h0000, 1'b1);
        @(posedge clk);
        mem <= '{1'b0, 1'b1, 16'h0000, 1'b0};
        @(posedge clk);
        mem <= '0;
        rdc(TMC_IDX_STAT1, 16'h4000);
        chk(32'(int_req), 32'h0000_0001);
        apb(TMC_IDX_CFG2, 1'b1, 16'h0000);
        mwr(16'h0000, 1'b0);
        $display("parity done");
        end_sim();
    end
endmodule // tb
